// [hdl/ge_consts.svh]
`ifndef GE_CONSTS_SVH
`define GE_CONSTS_SVH

// Register byte offsets, one aligned 32-bit word each.
`define GE_OFF_AUX_CMD      8'h00
`define GE_OFF_AUX_A        8'h04
`define GE_OFF_AUX_B        8'h08
`define GE_OFF_OUT_BYTE     8'h0c
`define GE_OFF_EOS_CHAR     8'h10
`define GE_OFF_CLK_FREQ     8'h14
`define GE_OFF_T1_NS        8'h18
`define GE_OFF_IRQ_STATUS   8'h1c
`define GE_OFF_IRQ_CLEAR    8'h20
`define GE_OFF_IRQ_ENABLE   8'h24
`define GE_OFF_STATE        8'h28

// Field positions.
`define GE_BIT_EOS_EOI      3
`define GE_BIT_SP_EOI       1
`define GE_BIT_EV_BYTE_OUT  0
`define GE_BIT_EV_EOI_SENT  1

// Auxiliary command codes.
`define GE_CMD_NBAF         8'h05
`define GE_CMD_FEOI         8'h08

// Reset values.
`define GE_RST_CLK_MHZ      8'h05
`define GE_RST_T1_NS        16'h01f4
`define GE_RST_BYTE         8'h00
`define GE_RST_IRQ          2'h0

// Timing arithmetic.
`define GE_NS_PER_US        25'h00003e8
`define GE_NS_ROUND         25'h00003e7
`define GE_MIN_CYCLES       16'h0001

`endif

// [hdl/ge_eoi_t1.sv]
// Our own choices: register access over Wishbone and the address map.
`include "ge_consts.svh"

// Operation
// - Assert EOI during controller parallel poll.
// - Serial-poll EOI enable asserts EOI in poll.
// - EOS match with enable asserts EOI when talking.
// - Force-EOI while talking asserts EOI with byte.
// - Force-EOI lasts through EOI byte and next.
// - Command code 5 clears force-EOI condition.
// - T1 is whole clock periods, rounded up.
// - Tolerate about half period extra latency.
// - Period count derived from frequency register.
// - Count depends on register, not real clock.
// - Frequency register defaults to five megahertz.

// Register map, one 32-bit word per register, by byte offset on the bus.
// Offset 00 takes auxiliary commands; 05 ends force-EOI and 08 starts it.
// Offset 04 holds control A, whose bit 3 lets an end-of-string match raise EOI.
// Offset 08 holds control B, whose bit 1 lets a serial poll response raise EOI.
// Offset 0c holds the outgoing byte, and a write to it starts the settling count.
// Offset 10 holds the end-of-string character that the outgoing byte is compared with.
// Offset 14 holds the clock frequency in whole megahertz and reads five after reset.
// Offset 18 holds the nominal settling time in nanoseconds and reads 500 after reset.
// Offset 1c shows the sticky events: bit 0 byte out, bit 1 byte sent with EOI.
// Offset 20 clears every event bit written as one; an event wins a tie with its clear.
// Offset 24 enables event bits onto the level interrupt output.
// Offset 28 shows the state: bits 1 to 0 the phase, bit 3 EOI, bit 4 force-EOI,
// bit 5 the first forced byte seen, bit 6 the EOI tag of the current byte, and
// bits 31 to 16 the cycle count last loaded for the settling delay.
// Unmapped offsets read as zero, ignore writes and are still acknowledged.
// Only byte lane 0 is used, except for the settling time, which uses lanes 0 and 1.
// Every request is acknowledged at the edge that takes it, for one cycle only.
// A master may hold its request through the acknowledge; it is not taken twice.
// Read data are registered with the acknowledge and stay until the next read.
// The interrupt output is a level, high while any enabled event bit is set.
//
// Host practice: to end a transfer, start force-EOI, write the last byte, wait for
// the byte-out event and then end force-EOI, so that no later byte carries EOI.
// Software programs the frequency rounded up to a whole megahertz; any larger value
// only lengthens the delays and is accepted as it stands.
// A frequency of zero still gives one period, so the settling phase always ends.
module ge_eoi_t1 (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  ge_pkg::ge_cond_t   cond_i,
    output logic      [7:0]    dio_o,
    output logic               data_valid_o,
    output logic               eoi_o,
    output logic               irq_o
);

    // The whole state sits in one packed record; n is its next value, built
    // afresh on every pass of the next-state logic and registered on every edge,
    // so no field can keep a stale value by being left out of a branch.
    ge_pkg::ge_state_t s;
    ge_pkg::ge_state_t n;

    // Number of clock periods for a nominal delay at the programmed frequency.
    // The product is in nanosecond-megahertz units, so dividing by 1000 gives
    // periods; adding 999 first rounds any remainder upward, and the delay never
    // falls short of its nominal value. Only the register value enters, never
    // the real clock, so a slower clock stretches the delay in proportion.
    function automatic logic [15:0] t1_cycles(input logic [15:0] t1_ns,
                                              input logic [7:0]  mhz);
        logic [24:0] prod;
        logic [24:0] q;
        prod = 25'(t1_ns) * 25'(mhz);
        q    = (prod + `GE_NS_ROUND) / `GE_NS_PER_US;
        if (q[15:0] < `GE_MIN_CYCLES) begin
            t1_cycles = `GE_MIN_CYCLES;
        end else begin
            t1_cycles = q[15:0];
        end
    endfunction

    // Byte-lane merge of a write into an 8-bit field held in lane 0.
    function automatic logic [7:0] merge8(input logic [7:0]  old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        merge8 = sel[0] ? dat[7:0] : old;
    endfunction

    // Sources of EOI; with none of them in effect the line stays low.
    function automatic logic eoi_next(input ge_pkg::ge_cond_t c,
                                      input logic [7:0]       aux_a,
                                      input logic [7:0]       aux_b,
                                      input logic [7:0]       out_byte,
                                      input logic [7:0]       eos_char,
                                      input logic             byte_eoi);
        logic pp_src;
        logic sp_src;
        logic eos_src;
        logic feoi_src;
        pp_src   = c.ctrl_parallel_poll;
        sp_src   = aux_b[`GE_BIT_SP_EOI] & c.serial_poll;
        eos_src  = aux_a[`GE_BIT_EOS_EOI] & c.talker_active
                   & (out_byte == eos_char);
        feoi_src = c.talker_active & byte_eoi;
        eoi_next = pp_src | sp_src | eos_src | feoi_src;
    endfunction

    // Sticky event bits: an event wins over a clear of the same bit in one cycle.
    function automatic logic [1:0] status_next(input logic [1:0] status,
                                               input logic [1:0] clr,
                                               input logic [1:0] set);
        status_next = (status & ~clr) | set;
    endfunction

    // Read data for a word offset; unmapped and write-only offsets read as zero.
    function automatic logic [31:0] read_word(input ge_pkg::ge_state_t st,
                                              input logic [7:0]       a);
        read_word = 32'h00000000;
        if (a == `GE_OFF_AUX_A) begin
            read_word = {24'h000000, st.aux_a};
        end else if (a == `GE_OFF_AUX_B) begin
            read_word = {24'h000000, st.aux_b};
        end else if (a == `GE_OFF_OUT_BYTE) begin
            read_word = {24'h000000, st.out_byte};
        end else if (a == `GE_OFF_EOS_CHAR) begin
            read_word = {24'h000000, st.eos_char};
        end else if (a == `GE_OFF_CLK_FREQ) begin
            read_word = {24'h000000, st.clk_mhz};
        end else if (a == `GE_OFF_T1_NS) begin
            read_word = {16'h0000, st.t1_ns};
        end else if (a == `GE_OFF_IRQ_STATUS) begin
            read_word = {30'h00000000, st.irq_status};
        end else if (a == `GE_OFF_IRQ_ENABLE) begin
            read_word = {30'h00000000, st.irq_enable};
        end else if (a == `GE_OFF_STATE) begin
            read_word = {st.last_cycles, 8'h00, 1'b0, st.byte_eoi, st.feoi_seen, st.feoi,
                         st.eoi, 1'b0, st.phase};
        end
    endfunction

    // Force-EOI progress: the first byte written after the command carries EOI,
    // the second byte ends the condition, and the clear command ends it at once,
    // dropping the EOI tag of the byte in hand as well.
    function automatic ge_pkg::ge_state_t feoi_step(input ge_pkg::ge_state_t st,
                                                    input ge_pkg::ge_state_t nx,
                                                    input logic              set_cmd,
                                                    input logic              clr_cmd,
                                                    input logic              new_byte);
        feoi_step = nx;
        if (set_cmd) begin
            feoi_step.feoi      = 1'b1;
            feoi_step.feoi_seen = 1'b0;
        end else if (clr_cmd) begin
            feoi_step.feoi      = 1'b0;
            feoi_step.feoi_seen = 1'b0;
            feoi_step.byte_eoi  = 1'b0;
        end else if (new_byte) begin
            feoi_step.byte_eoi = st.feoi & ~st.feoi_seen;
            if (st.feoi) begin
                feoi_step.feoi_seen = 1'b1;
                if (st.feoi_seen) begin
                    feoi_step.feoi      = 1'b0;
                    feoi_step.feoi_seen = 1'b0;
                end
            end
        end
    endfunction

    // One edge of the settling count; a new byte restarts it from the full count.
    function automatic ge_pkg::ge_state_t settle_step(input ge_pkg::ge_state_t st,
                                                      input ge_pkg::ge_state_t nx,
                                                      input logic              new_byte);
        settle_step = nx;
        case (st.phase)
            ge_pkg::GE_SETTLE: begin
                if (st.cnt <= `GE_MIN_CYCLES) begin
                    settle_step.phase = ge_pkg::GE_VALID;
                end else begin
                    settle_step.cnt = st.cnt - `GE_MIN_CYCLES;
                end
            end
            ge_pkg::GE_VALID: begin
                settle_step.phase = ge_pkg::GE_VALID;
            end
            default: begin
                settle_step.phase = ge_pkg::GE_IDLE;
            end
        endcase
        if (new_byte) begin
            settle_step.cnt         = t1_cycles(st.t1_ns, st.clk_mhz);
            settle_step.last_cycles = settle_step.cnt;
            settle_step.phase       = ge_pkg::GE_SETTLE;
        end
    endfunction

    // Events posted at the edge that ends the settling count.
    function automatic logic [1:0] settle_events(input ge_pkg::ge_state_t st);
        logic done;
        done = (st.phase == ge_pkg::GE_SETTLE) && (st.cnt <= `GE_MIN_CYCLES);
        settle_events[`GE_BIT_EV_BYTE_OUT] = done;
        settle_events[`GE_BIT_EV_EOI_SENT] = done & st.eoi;
    endfunction

    // Decoded request and strobes, all given a value on every pass below.
    logic        req;
    logic        wr;
    logic        rd;
    logic [7:0]  adr;
    logic        byte_wr;
    logic        feoi_cmd;
    logic        nbaf_cmd;
    logic [1:0]  irq_clr;
    logic [1:0]  irq_set;
    logic [31:0] rmux;

    // A request is taken at the edge where cycle and strobe are high and the
    // acknowledge is low. The acknowledge then stands for exactly one cycle,
    // which also blocks a request that the master still holds from being
    // taken a second time. Writes land at the edge that takes the request,
    // and read data are captured at that edge, to stand with the acknowledge.
    always_comb begin
        n        = s;
        req      = wb_cyc_i & wb_stb_i & ~s.ack;
        wr       = req & wb_we_i;
        rd       = req & ~wb_we_i;
        adr      = {wb_adr_i[7:2], 2'b00};
        byte_wr  = 1'b0;
        feoi_cmd = 1'b0;
        nbaf_cmd = 1'b0;
        irq_clr  = 2'b00;
        irq_set  = 2'b00;
        rmux     = 32'h00000000;
        n.ack    = req;

        // Register writes take effect at the edge that takes the request.
        // A command code other than the two known ones is ignored, and so
        // are lanes other than those that a register uses.
        if (wr) begin
            if (adr == `GE_OFF_AUX_CMD) begin
                if (wb_sel_i[0] && wb_dat_i[7:0] == `GE_CMD_FEOI) begin
                    feoi_cmd = 1'b1;
                end else if (wb_sel_i[0] && wb_dat_i[7:0] == `GE_CMD_NBAF) begin
                    nbaf_cmd = 1'b1;
                end
            end else if (adr == `GE_OFF_AUX_A) begin
                n.aux_a = merge8(s.aux_a, wb_dat_i, wb_sel_i);
            end else if (adr == `GE_OFF_AUX_B) begin
                n.aux_b = merge8(s.aux_b, wb_dat_i, wb_sel_i);
            end else if (adr == `GE_OFF_OUT_BYTE) begin
                if (wb_sel_i[0]) begin
                    n.out_byte = wb_dat_i[7:0];
                    byte_wr    = 1'b1;
                end
            end else if (adr == `GE_OFF_EOS_CHAR) begin
                n.eos_char = merge8(s.eos_char, wb_dat_i, wb_sel_i);
            end else if (adr == `GE_OFF_CLK_FREQ) begin
                n.clk_mhz = merge8(s.clk_mhz, wb_dat_i, wb_sel_i);
            end else if (adr == `GE_OFF_T1_NS) begin
                if (wb_sel_i[0]) begin
                    n.t1_ns[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    n.t1_ns[15:8] = wb_dat_i[15:8];
                end
            end else if (adr == `GE_OFF_IRQ_CLEAR) begin
                if (wb_sel_i[0]) begin
                    irq_clr = wb_dat_i[1:0];
                end
            end else if (adr == `GE_OFF_IRQ_ENABLE) begin
                if (wb_sel_i[0]) begin
                    n.irq_enable = wb_dat_i[1:0];
                end
            end
        end

        // Register reads; the data stand until the next read replaces them.
        rmux = read_word(s, adr);
        if (rd) begin
            n.rdata = rmux;
        end

        // Force-EOI: the first byte written carries EOI, the second ends the condition.
        n = feoi_step(s, n, feoi_cmd, nbaf_cmd, byte_wr);

        // T1 settling walk: a byte written at edge E loads the count N and enters
        // the settle phase; the count steps down once per edge until it reaches
        // one, and the next edge, E plus N, raises data valid and posts the
        // byte-out event. A byte written during settle restarts the count.
        // The count comes from the register, never from the real clock, and it
        // is at least one period, so the phase always ends.
        n       = settle_step(s, n, byte_wr);
        irq_set = settle_events(s);

        // Event bits are sticky until cleared; an event and its clear in one
        // cycle leave the bit set, so no event is ever lost.
        n.irq_status = status_next(s.irq_status, irq_clr, irq_set);

        // EOI is registered, so it follows its causes by one edge and never glitches.
        n.eoi = eoi_next(cond_i, s.aux_a, s.aux_b, s.out_byte, s.eos_char, s.byte_eoi);
    end

    // Reset is synchronous and brings back the five megahertz default, so a
    // host that never programs the frequency still gets sensible delays.
    // During reset EOI, data valid, acknowledge and interrupt are all low.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s            <= '0;
            s.clk_mhz    <= `GE_RST_CLK_MHZ;
            s.t1_ns      <= `GE_RST_T1_NS;
            s.out_byte   <= `GE_RST_BYTE;
            s.eos_char   <= `GE_RST_BYTE;
            s.irq_status <= `GE_RST_IRQ;
            s.irq_enable <= `GE_RST_IRQ;
            s.phase      <= ge_pkg::GE_IDLE;
        end else begin
            s <= n;
        end
    end

    // The data-valid edge follows the counted settle; downstream sampling of the
    // bus adds its own synchronising delay, which listeners must tolerate.
    // That extra latency, about half a period, is not modelled here: data
    // valid rises exactly N edges after the byte write. The outgoing byte,
    // EOI and the read data all come straight from flip-flops, so they are
    // settled well before the next edge. The interrupt is the AND of two
    // registers and carries no combinational path from the bus.
    // The settling count is 16 bits wide, which covers the largest product of
    // nominal time and frequency that the two registers can hold.
    assign data_valid_o = (s.phase == ge_pkg::GE_VALID);
    assign dio_o        = s.out_byte;
    assign eoi_o        = s.eoi;
    assign irq_o        = |(s.irq_status & s.irq_enable);
    assign wb_ack_o     = s.ack;
    assign wb_dat_o     = s.rdata;

endmodule // ge_eoi_t1

// [hdl/ge_pkg.sv]
package ge_pkg;

    // Gray-coded phase of the outgoing byte: idle, settling, valid.
    typedef enum logic [1:0] {
        GE_IDLE   = 2'b00,
        GE_SETTLE = 2'b01,
        GE_VALID  = 2'b11
    } ge_phase_t;

    typedef struct packed {
        logic [7:0]  aux_a;
        logic [7:0]  aux_b;
        logic [7:0]  out_byte;
        logic [7:0]  eos_char;
        logic [7:0]  clk_mhz;
        logic [15:0] t1_ns;
        logic        feoi;
        logic        feoi_seen;
        logic        byte_eoi;
        logic [15:0] cnt;
        logic [15:0] last_cycles;
        ge_phase_t   phase;
        logic [1:0]  irq_status;
        logic [1:0]  irq_enable;
        logic        eoi;
        logic        ack;
        logic [31:0] rdata;
    } ge_state_t;

    // Requester-side poll and talker conditions seen by the EOI logic.
    typedef struct packed {
        logic ctrl_parallel_poll;
        logic serial_poll;
        logic talker_active;
    } ge_cond_t;

endpackage

// [verification/ge_bus_peer.sv]
module ge_bus_peer (
    input  wire logic        clk_i,
    input  wire logic [2:0]  mode_i,
    output ge_pkg::ge_cond_t cond_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_i) begin
        cond_o <= ge_pkg::ge_cond_t'(mode_i);
    end
endmodule // ge_bus_peer

// [verification/ge_eoi_t1_properties.sv]
`include "ge_consts.svh"
module ge_chk (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [7:0]       wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic             wb_ack_o,
    input wire ge_pkg::ge_cond_t cond_i,
    input wire logic [7:0]       dio_o,
    input wire logic             data_valid_o,
    input wire logic             eoi_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire  take = wb_cyc_i & wb_stb_i & !wb_ack_o & wb_sel_i[0];
    wire  bw   = take & wb_we_i & ((wb_adr_i & 8'hfc) == `GE_OFF_OUT_BYTE);
    logic spen;
    // Mirror of the serial-poll EOI enable, taken from the register writes.
    always_ff @(posedge clk_i) begin
        if (rst_i)
            spen <= 1'b0;
        else if (take && wb_we_i && (wb_adr_i & 8'hfc) == `GE_OFF_AUX_B)
            spen <= wb_dat_i[1];
    end
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_byte_load: assert property (bw |=> dio_o == $past(wb_dat_i[7:0]) && !data_valid_o)
        else $error("byte not loaded or settle skipped");
    a_valid_hold: assert property (data_valid_o && !bw |=> data_valid_o)
        else $error("valid dropped without new byte");
    a_dio_stable: assert property (!bw |=> $stable(dio_o))
        else $error("outgoing byte changed unprompted");
    a_pp_eoi: assert property (cond_i.ctrl_parallel_poll |=> eoi_o)
        else $error("eoi missing in parallel poll");
    a_sp_eoi: assert property (cond_i.serial_poll && spen |=> eoi_o)
        else $error("eoi missing in serial poll");
    a_no_cause: assert property (cond_i == 3'b000 |=> !eoi_o)
        else $error("eoi without cause");
endmodule // ge_chk
bind ge_eoi_t1 ge_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .cond_i, .dio_o, .data_valid_o, .eoi_o);

// [verification/ge_eoi_t1_tb.sv]
`include "ge_consts.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: got %h, expected %h", $time, a, b); end end
module ge_eoi_t1_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, dv, eoi, irq;
    logic [7:0]  adr = 8'h00, dio;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, lfsr = 32'h2cc59c34, q[$];
    logic [2:0]  mode = 3'h0;
    logic [31:0] exp_d;
    ge_pkg::ge_cond_t cond;
    int          fail_count = 0, n_checks = 0, cnt, i;
    int          tn[3] = '{500, 500, 2000}, tm[3] = '{5, 16, 2};
    always #10 clk_i = ~clk_i;
    ge_bus_peer peer_u (.clk_i(clk_i), .mode_i(mode), .cond_o(cond));
    ge_eoi_t1 dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cond_i(cond), .dio_o(dio), .data_valid_o(dv), .eoi_o(eoi),
        .irq_o(irq));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // A read's expected data travels in d and waits in the queue for the ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        if (!w) q.push_back(d);
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic ce(input logic e);
        repeat (3) @(posedge clk_i);
        `CHK(eoi, e)
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && !we) begin
            exp_d = q.pop_front();
            `CHK(rdat, exp_d)
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        wb(0, `GE_OFF_CLK_FREQ, 32'h5);
        wb(0, `GE_OFF_T1_NS, 32'h1f4);
        wb(0, 8'h3c, 32'h0);
        $display("Test reset values done");
        for (i = 0; i < 3; i++) begin
            wb(1, `GE_OFF_CLK_FREQ, 32'(tm[i]));
            wb(1, `GE_OFF_T1_NS, 32'(tn[i]));
            lfsr = nxt(lfsr);
            wb(1, `GE_OFF_OUT_BYTE, {24'h0, lfsr[7:0]});
            cnt = 1;
            while (dv !== 1'b1) begin
                @(posedge clk_i);
                cnt++;
            end
            `CHK(cnt, (tn[i] * tm[i] + 999) / 1000 + 1)
            `CHK(dio, lfsr[7:0])
        end
        $display("Test settle delay done");
        mode <= 3'b100;
        ce(1'b1);
        mode <= 3'b010;
        ce(1'b0);
        wb(1, `GE_OFF_AUX_B, 32'h2);
        ce(1'b1);
        wb(1, `GE_OFF_AUX_B, 32'h0);
        mode <= 3'b001;
        wb(1, `GE_OFF_EOS_CHAR, 32'h5a);
        wb(1, `GE_OFF_AUX_A, 32'h8);
        wb(1, `GE_OFF_OUT_BYTE, 32'h5a);
        ce(1'b1);
        wb(1, `GE_OFF_OUT_BYTE, 32'h5b);
        ce(1'b0);
        wb(1, `GE_OFF_AUX_CMD, {24'h0, `GE_CMD_FEOI});
        wb(1, `GE_OFF_OUT_BYTE, 32'h81);
        ce(1'b1);
        wb(1, `GE_OFF_OUT_BYTE, 32'h82);
        ce(1'b0);
        wb(1, `GE_OFF_IRQ_CLEAR, 32'h3);
        wb(1, `GE_OFF_IRQ_ENABLE, 32'h1);
        wb(1, `GE_OFF_AUX_CMD, {24'h0, `GE_CMD_FEOI});
        wb(1, `GE_OFF_OUT_BYTE, 32'h83);
        while (irq !== 1'b1) @(posedge clk_i);
        `CHK(eoi, 1'b1)
        wb(0, `GE_OFF_IRQ_STATUS, 32'h3);
        wb(1, `GE_OFF_AUX_CMD, {24'h0, `GE_CMD_NBAF});
        ce(1'b0);
        wb(1, `GE_OFF_IRQ_ENABLE, 32'h0);
        `CHK(irq, 1'b0)
        wb(1, `GE_OFF_IRQ_CLEAR, 32'h3);
        wb(0, `GE_OFF_IRQ_STATUS, 32'h0);
        $display("Test eoi and interrupt done");
        end_sim;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        end_sim;
    end
    task end_sim;
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
endmodule // ge_eoi_t1_tb
